// *** wdrt_pkg.sv ***
// Package: register map, field layout and constants of the watchdog
package wdrt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000; // watchdog_control
  localparam logic [11:0] PROTECT_KEY_FIELD_ADDR = 12'h004; // system_protect_register
  localparam logic [11:0] STAT_ADDR = 12'h008; // counter value view

  // ----------------------------------------------------------------
  // Field layout and keys
  // ----------------------------------------------------------------
  localparam int RUN_LSB = 0;
  localparam int RUN_MSB = 3;
  localparam int CLR_BIT = 4;
  localparam logic [3:0] STOP_KEY = 4'ha;
  localparam logic [15:0] UNLOCK_KEY = 16'h0096;
  localparam logic [3:0] RUN_RESET = 4'ha;   // Stopped after reset
  localparam int CNT_W = 10;                 // Ten-bit up counter
  localparam logic [9:0] CNT_MAX = 10'h3ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Software visible control state
  typedef struct packed {
    logic [3:0] runKey;
    logic unlocked;
  } wdrt_ctrl_type;

  // Bus response state
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } wdrt_resp_type;

endpackage

// *** wdrt_watchdog.sv ***
// Watchdog reset timer with APB register access
`timescale 1ns/1ps
module wdrt_watchdog (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic srcTick,   // Selected clock source tick (async pin)
  output logic sysReset       // Registered system reset request
);

  // ----------------------------------------------------------------
  // Source tick synchroniser and edge detect
  // ----------------------------------------------------------------
  logic tickMeta_q, tickSync_q, tickOld_q;
  logic tickMeta_d, tickSync_d, tickOld_d;
  logic tickEdge;

  // Next values: meta stage feeds only the sync stage
  always_comb
  begin
    tickMeta_d = srcTick;
    tickSync_d = tickMeta_q;
    tickOld_d = tickSync_q;
  end

  // Register synchroniser stages
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tickMeta_q <= 1'b0;
      tickSync_q <= 1'b0;
      tickOld_q <= 1'b0;
    end
    else
    begin
      tickMeta_q <= tickMeta_d;
      tickSync_q <= tickSync_d;
      tickOld_q <= tickOld_d;
    end
  end

  // A stopped source makes no edges, so the count simply holds
  assign tickEdge = tickSync_q & ~tickOld_q;

  // ----------------------------------------------------------------
  // APB slave and control registers
  // ----------------------------------------------------------------
  wdrt_pkg::wdrt_ctrl_type ctrl_q, ctrl_d;
  wdrt_pkg::wdrt_resp_type resp_q, resp_d;
  logic clrReq;            // One-cycle counter clear request
  logic setupPhase;
  logic accessDone;        // Access edge at which pready is high
  logic [wdrt_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic rst_q, rst_d;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & resp_q.ready;

  // Decode bus access; answer one cycle after setup
  always_comb
  begin
    ctrl_d = ctrl_q;
    resp_d = '0;
    clrReq = 1'b0;
    if (setupPhase)
    begin
      resp_d.ready = 1'b1;
      unique case (paddr)
        wdrt_pkg::CTRL_ADDR:
        begin
          // Reserved bits and clear bit read as zero
          resp_d.rdata = {28'h0000000, ctrl_q.runKey};
        end
        wdrt_pkg::PROTECT_KEY_FIELD_ADDR:
        begin
          resp_d.rdata = {31'h0, ctrl_q.unlocked};
        end
        wdrt_pkg::STAT_ADDR:
        begin
          resp_d.rdata = {22'h0, cnt_q};
        end
        default:
        begin
          resp_d.slverr = 1'b1; // Unmapped address
        end
      endcase
    end
    // Writes land at the access edge where the master sees pready,
    // so an abandoned setup cycle never changes state
    if (accessDone && pwrite)
    begin
      if (paddr == wdrt_pkg::CTRL_ADDR)
      begin
        // Protected write: ignored while locked
        if (ctrl_q.unlocked)
        begin
          ctrl_d.runKey = pwdata[wdrt_pkg::RUN_MSB:wdrt_pkg::RUN_LSB];
          clrReq = pwdata[wdrt_pkg::CLR_BIT];
        end
      end
      else if (paddr == wdrt_pkg::PROTECT_KEY_FIELD_ADDR)
      begin
        // Only the unlock key opens; anything else relocks
        ctrl_d.unlocked = (pwdata[15:0] == wdrt_pkg::UNLOCK_KEY);
      end
    end
  end

  // Register control state and bus response
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= '{runKey: wdrt_pkg::RUN_RESET, unlocked: 1'b0};
      resp_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      resp_q <= resp_d;
    end
  end

  // Answer stands for the single access cycle only
  assign pready = resp_q.ready;
  assign pslverr = resp_q.slverr;
  assign prdata = resp_q.rdata;

  // ----------------------------------------------------------------
  // Counter and reset generation
  // ----------------------------------------------------------------
  logic running;
  assign running = (ctrl_q.runKey != wdrt_pkg::STOP_KEY);

  // Clear beats a tick; HALT/SLEEP are not inputs, count never gates
  always_comb
  begin
    cnt_d = cnt_q;
    rst_d = 1'b0;
    if (clrReq)
      cnt_d = '0;
    else if (running && tickEdge)
    begin
      if (cnt_q == wdrt_pkg::CNT_MAX)
      begin
        cnt_d = '0;
        rst_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 10'h001;
    end
    // Stop key freezes counting and overflow; a clear still zeroes the count
  end

  // Register counter and reset request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      rst_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  assign sysReset = rst_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_overflow_resets: assert property (@(posedge clk) disable iff (reset)
    (running && tickEdge && !clrReq && cnt_q == wdrt_pkg::CNT_MAX)
      |=> sysReset)
    else $error("overflow did not raise reset");

  a_reset_cause: assert property (@(posedge clk) disable iff (reset)
    sysReset |-> $past(cnt_q) == wdrt_pkg::CNT_MAX)
    else $error("reset without overflow");

  a_clear_zero: assert property (@(posedge clk) disable iff (reset)
    clrReq |=> cnt_q == '0)
    else $error("clear did not zero counter");

  a_clear_write: assert property (@(posedge clk) disable iff (reset)
    (accessDone && pwrite && paddr == wdrt_pkg::CTRL_ADDR &&
     ctrl_q.unlocked && pwdata[wdrt_pkg::CLR_BIT]) |=> cnt_q == '0)
    else $error("clear bit write ignored");

  a_stop_holds: assert property (@(posedge clk) disable iff (reset)
    (!running && !clrReq) |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  a_no_tick_hold: assert property (@(posedge clk) disable iff (reset)
    (!tickEdge && !clrReq) |=> $stable(cnt_q) && !sysReset)
    else $error("counter moved without source tick");

  a_run_counts: assert property (@(posedge clk) disable iff (reset)
    (running && tickEdge && !clrReq && cnt_q != wdrt_pkg::CNT_MAX)
      |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("running counter did not advance");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (pready && $past(paddr) == wdrt_pkg::CTRL_ADDR)
      |-> prdata[31:4] == 28'h0000000)
    else $error("reserved control bits not zero");

endmodule // wdrt_watchdog

// *** wdrt_tb.sv ***
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0; // 100 MHz clock
  logic reset = 1'b1; // Async reset, held four cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sysReset;
  logic srcTick = 1'b0; // Kept far below clk/2 so the synchroniser sees it
  int mismatches = 0;
  int checks_done = 0;
  int rstSeen = 0; // System reset pulses seen
  always #5 clk = ~clk;
  wdrt_watchdog wdrt_watchdog_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcTick(srcTick), .sysReset(sysReset));
  // Count one-cycle reset pulses
  always @(posedge clk)
    if (sysReset === 1'b1) rstSeen <= rstSeen + 1;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk("pslverr", {31'h0, ex}, {31'h0, e});
  endtask
  // Source clock edges, each counted once
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      srcTick <= 1'b1;
      repeat (4) @(posedge clk);
      srcTick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_locked();
    rd("ctrl", wdrt_pkg::CTRL_ADDR, 32'ha, 1'b0);
    rd("protect_key_field", wdrt_pkg::PROTECT_KEY_FIELD_ADDR, 32'h0, 1'b0);
    wr(wdrt_pkg::CTRL_ADDR, 32'h15); // Ignored while locked
    rd("ctrl", wdrt_pkg::CTRL_ADDR, 32'ha, 1'b0);
    rd("unmapped", 12'h00c, 32'h0, 1'b1);
  endtask
  task automatic t_start();
    wr(wdrt_pkg::PROTECT_KEY_FIELD_ADDR, 32'h96);
    wr(wdrt_pkg::CTRL_ADDR, 32'hffff_fff5);
    rd("ctrl", wdrt_pkg::CTRL_ADDR, 32'h5, 1'b0);
    wr(wdrt_pkg::PROTECT_KEY_FIELD_ADDR, 32'h0);
    rd("protect_key_field", wdrt_pkg::PROTECT_KEY_FIELD_ADDR, 32'h0, 1'b0);
    wr(wdrt_pkg::CTRL_ADDR, 32'ha); // Relocked: must be ignored
    rd("ctrl", wdrt_pkg::CTRL_ADDR, 32'h5, 1'b0);
    tick(5);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h5, 1'b0);
  endtask
  task automatic t_clear();
    wr(wdrt_pkg::PROTECT_KEY_FIELD_ADDR, 32'h96);
    wr(wdrt_pkg::CTRL_ADDR, 32'h15);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h0, 1'b0);
    tick(3);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h3, 1'b0);
  endtask
  task automatic t_stop();
    repeat (50) @(posedge clk); // Running, source stopped: count holds
    rd("count", wdrt_pkg::STAT_ADDR, 32'h3, 1'b0);
    chk("resets", 32'h0, rstSeen);
    wr(wdrt_pkg::CTRL_ADDR, 32'ha);
    tick(4);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h3, 1'b0);
    repeat (50) @(posedge clk);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h3, 1'b0);
  endtask
  task automatic t_overflow();
    wr(wdrt_pkg::CTRL_ADDR, 32'h1f);
    tick(1023);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h3ff, 1'b0);
    chk("resets", 32'h0, rstSeen);
    tick(1);
    rd("count", wdrt_pkg::STAT_ADDR, 32'h0, 1'b0);
    chk("resets", 32'h1, rstSeen);
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_locked();
    t_start();
    t_clear();
    t_stop();
    t_overflow();
    wrap_up();
  end
  // Tests need about 90 us; cut a hang well after that
  initial
  begin
    #300us;
    mismatches++;
    wrap_up();
  end
endmodule // tb
